// File: design/uvtl_regs.vh
// Register map, field layout, reset values and timing constants of the undervoltage/overload block
`ifndef UVTL_REGS_VH
`define UVTL_REGS_VH

// Clock rate and millisecond time base
`define UVTL_CLK_HZ          40000000
`define UVTL_TICK_HZ         1000
`define UVTL_MS_CYCLES       (`UVTL_CLK_HZ / `UVTL_TICK_HZ)

// Register byte offsets
`define UVTL_OFS_CTRL        8'h00
`define UVTL_OFS_UV_LIMIT    8'h04
`define UVTL_OFS_RELEASE     8'h08
`define UVTL_OFS_HOLD        8'h0C
`define UVTL_OFS_WARN_LEVEL  8'h10
`define UVTL_OFS_DERATING    8'h14
`define UVTL_OFS_STATUS      8'h18
`define UVTL_OFS_INT_STATUS  8'h1C
`define UVTL_OFS_INT_MASK    8'h20
`define UVTL_OFS_ALARM_LEVEL 8'h24

// Control register fields
`define UVTL_CTRL_MODE_LO    0
`define UVTL_CTRL_MODE_HI    1
`define UVTL_CTRL_RESTART    8
`define UVTL_CTRL_ALM_CLR    9

// Undervoltage handling modes
`define UVTL_MODE_OFF        2'h0
`define UVTL_MODE_HOST       2'h1
`define UVTL_MODE_INTERNAL   2'h2

// Reset values and ranges
`define UVTL_RST_UV_LIMIT    7'd50
`define UVTL_RST_RELEASE     10'd100
`define UVTL_RST_HOLD        10'd20
`define UVTL_RST_WARN_LEVEL  7'd20
`define UVTL_RST_DERATING    7'd100
`define UVTL_RST_ALARM_LEVEL 24'h00_2000
`define UVTL_PCT_MAX         7'd100
`define UVTL_DERATE_MIN      7'd10
`define UVTL_HOLD_MIN        10'd20
`define UVTL_TIME_MAX        10'd1000
`define UVTL_NORMAL_LIMIT    7'd100

// Fixed current levels, in motor current units
`define UVTL_BASE_CURRENT    16'h0400
`define UVTL_HIGH_LOAD_LEVEL 16'h0C00

// Interrupt status bits
`define UVTL_INT_UV          0
`define UVTL_INT_OL_WARN     1
`define UVTL_INT_OL_ALARM    2
`define UVTL_INT_POWER_TRIP  3
`define UVTL_INT_HIGH_ALARM  4
`define UVTL_INT_W           5

`endif

// File: design/uvtl_top.v
// Undervoltage torque limit, power cut hold and overload timing with an APB register slave
// Notes on behaviour
// - The undervoltage mode selects off, warning with host limiting, or warning with internal limiting.
// - In internal mode the torque limit is clamped to the undervoltage limit while the warning stands.
// - After the warning clears in internal mode the limit returns to normal over 0 to 1000 ms, default 100.
// - The undervoltage torque limit spans 0 to 100 percent, default 50, and applies at once.
// - The overload warning rises at 1 to 100 percent, default 20, of the alarm detection time.
// - The warning output is asserted when the overload warning is detected.
// - Low-load overload accumulation starts above base current times the derating, 10 to 127 (values below 10 raised), on restart.
// - The warning point follows the alarm timing, so the derating also moves the warning.
// - The high-load alarm level and characteristic stay fixed whatever the settings.
// - Switching servo-on off cuts motor current at once regardless of the hold time.
// - A power cut shorter than the hold time is ridden through; a longer one cuts power and drops ready.
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uvtl_regs.vh"

module uvtl_top
#(
	parameter MS_CYCLES = `UVTL_MS_CYCLES
)
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        clk_en,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        uv_detect,
	input  wire        main_power_ok,
	input  wire        servo_on,
	input  wire [15:0] motor_current,
	output reg  [6:0]  torque_limit,
	output reg         uv_warning,
	output reg         warn_out,
	output reg         ol_alarm_low,
	output reg         ol_alarm_high,
	output reg         servo_ready,
	output reg         motor_power_en,
	output reg         irq
);

	// Configuration registers
	reg  [1:0]  mode_pending;
	reg  [1:0]  mode_active;
	reg  [6:0]  uv_limit;
	reg  [9:0]  release_time;
	reg  [9:0]  hold_time;
	reg  [6:0]  warn_level;
	reg  [6:0]  derate_pending;
	reg  [6:0]  derate_active;
	reg  [23:0] alarm_level;
	reg  [`UVTL_INT_W-1:0] int_status;
	reg  [`UVTL_INT_W-1:0] int_mask;

	// Internal state
	reg  [15:0] ms_count;
	reg         ms_tick;
	reg         releasing;
	reg  [9:0]  release_elapsed;
	reg  [6:0]  release_start;
	reg  [9:0]  cut_elapsed;
	reg         power_tripped;
	reg  [23:0] ol_accum;

	wire        access   = psel & penable & pready;
	wire        wr_en    = access & pwrite;
	wire        rd_en    = access & ~pwrite;
	wire        hit_ctrl = (paddr == `UVTL_OFS_CTRL);

	// Saturating clamps; out-of-range writes are held, the clamp only acts on use
	wire [6:0]  uv_lim_c  = (uv_limit > `UVTL_PCT_MAX) ? `UVTL_PCT_MAX : uv_limit;
	wire [9:0]  rel_c     = (release_time > `UVTL_TIME_MAX) ? `UVTL_TIME_MAX : release_time;
	wire [9:0]  hold_c    = (hold_time < `UVTL_HOLD_MIN) ? `UVTL_HOLD_MIN :
	                        (hold_time > `UVTL_TIME_MAX) ? `UVTL_TIME_MAX : hold_time;
	wire [6:0]  wlev_c    = (warn_level == 7'd0) ? 7'd1 :
	                        (warn_level > `UVTL_PCT_MAX) ? `UVTL_PCT_MAX : warn_level;

	// Derated base current, fixed until the next restart
	wire [22:0] derate_prod = `UVTL_BASE_CURRENT * derate_active;
	wire [22:0] derate_quo = derate_prod / `UVTL_PCT_MAX;
	wire [15:0] derated_base = derate_quo[15:0]; // At most 127 percent of the base current, so the cut is lossless

	// Warning point scales with the alarm point, so any alarm timing change moves it too
	wire [30:0] warn_prod = alarm_level * wlev_c;
	wire [30:0] warn_quo = warn_prod / `UVTL_PCT_MAX;
	wire [23:0] warn_point = warn_quo[23:0]; // Never above the alarm level

	// Ramp value: start + span * elapsed / duration, monotonic in elapsed
	wire [6:0]  ramp_span = `UVTL_NORMAL_LIMIT - release_start;
	wire [16:0] ramp_prod = ramp_span * release_elapsed;
	wire [16:0] ramp_step = (rel_c == 10'd0) ? {10'd0, ramp_span} : ramp_prod / rel_c;
	wire [6:0]  ramp_value = release_start + ramp_step[6:0];

	wire        uv_now  = (mode_active != `UVTL_MODE_OFF) & uv_detect;
	wire [15:0] over    = motor_current - derated_base;
	wire        ol_warn_now  = (ol_accum >= warn_point);
	wire        ol_alarm_now = (ol_accum >= alarm_level);
	wire        high_now     = (motor_current >= `UVTL_HIGH_LOAD_LEVEL);

	wire [`UVTL_INT_W-1:0] events;
	wire [`UVTL_INT_W-1:0] clr_bits;
	assign events[`UVTL_INT_UV]         = uv_now & ~uv_warning;
	assign events[`UVTL_INT_OL_WARN]    = ol_warn_now & ~warn_out;
	assign events[`UVTL_INT_OL_ALARM]   = ol_alarm_now & ~ol_alarm_low;
	assign events[`UVTL_INT_POWER_TRIP] = ms_tick & ~main_power_ok & ~power_tripped &
	                                      (cut_elapsed + 10'd1 >= hold_c);
	assign events[`UVTL_INT_HIGH_ALARM] = high_now & ~ol_alarm_high;
	assign clr_bits = (wr_en && paddr == `UVTL_OFS_INT_STATUS) ? pwdata[`UVTL_INT_W-1:0] : 
	                  {`UVTL_INT_W{1'b0}};

	wire [`UVTL_INT_W-1:0] next_int_status;
	genvar gi;
	// Sticky bits: an event in the clearing cycle survives
	generate
		for (gi = 0; gi < `UVTL_INT_W; gi = gi + 1)
		begin : g_sticky
			assign next_int_status[gi] = events[gi] | (int_status[gi] & ~clr_bits[gi]);
		end
	endgenerate

	// APB answers one cycle into the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else if (clk_en)
			pready <= psel & penable & ~pready;
	end

	// Register writes and restart handling
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_pending   <= `UVTL_MODE_OFF;
			mode_active    <= `UVTL_MODE_OFF;
			uv_limit       <= `UVTL_RST_UV_LIMIT;
			release_time   <= `UVTL_RST_RELEASE;
			hold_time      <= `UVTL_RST_HOLD;
			warn_level     <= `UVTL_RST_WARN_LEVEL;
			derate_pending <= `UVTL_RST_DERATING;
			derate_active  <= `UVTL_RST_DERATING;
			alarm_level    <= `UVTL_RST_ALARM_LEVEL;
			int_mask       <= {`UVTL_INT_W{1'b0}};
		end
		else if (clk_en && wr_en)
		begin
			case (paddr)
				`UVTL_OFS_CTRL:
				begin
					mode_pending <= pwdata[`UVTL_CTRL_MODE_HI:`UVTL_CTRL_MODE_LO];
					if (pwdata[`UVTL_CTRL_RESTART])
					begin
						mode_active   <= pwdata[`UVTL_CTRL_MODE_HI:`UVTL_CTRL_MODE_LO];
						derate_active <= (derate_pending < `UVTL_DERATE_MIN) ?
						                 `UVTL_DERATE_MIN : derate_pending;
					end
				end
				`UVTL_OFS_UV_LIMIT:    uv_limit       <= pwdata[6:0];
				`UVTL_OFS_RELEASE:     release_time   <= pwdata[9:0];
				`UVTL_OFS_HOLD:        hold_time      <= pwdata[9:0];
				`UVTL_OFS_WARN_LEVEL:  warn_level     <= pwdata[6:0];
				`UVTL_OFS_DERATING:    derate_pending <= pwdata[6:0];
				`UVTL_OFS_INT_MASK:    int_mask       <= pwdata[`UVTL_INT_W-1:0];
				`UVTL_OFS_ALARM_LEVEL: alarm_level    <= pwdata[23:0];
				default:               int_mask       <= int_mask;
			endcase
		end
	end

	// Read mux and error answer for unmapped addresses
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pslverr <= 1'b0;
			if (psel && penable && !pready)
			begin
				prdata <= 32'h0000_0000;
				case (paddr)
					`UVTL_OFS_CTRL:        prdata[1:0]  <= mode_pending;
					`UVTL_OFS_UV_LIMIT:    prdata[6:0]  <= uv_limit;
					`UVTL_OFS_RELEASE:     prdata[9:0]  <= release_time;
					`UVTL_OFS_HOLD:        prdata[9:0]  <= hold_time;
					`UVTL_OFS_WARN_LEVEL:  prdata[6:0]  <= warn_level;
					`UVTL_OFS_DERATING:    prdata[6:0]  <= derate_pending;
					`UVTL_OFS_STATUS:      prdata[31:0] <= {derate_active, mode_active, releasing,
					                                        torque_limit, 9'h000, ol_alarm_high,
					                                        power_tripped, servo_ready,
					                                        ol_alarm_low, warn_out, uv_warning};
					`UVTL_OFS_INT_STATUS:  prdata[`UVTL_INT_W-1:0] <= int_status;
					`UVTL_OFS_INT_MASK:    prdata[`UVTL_INT_W-1:0] <= int_mask;
					`UVTL_OFS_ALARM_LEVEL: prdata[23:0] <= alarm_level;
					default:               pslverr      <= 1'b1;
				endcase
			end
		end
	end

	// Millisecond time base; long count is a parameter so benches can shorten it
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_count <= 16'h0000;
			ms_tick  <= 1'b0;
		end
		else if (clk_en)
		begin
			ms_tick <= (ms_count == MS_CYCLES[15:0] - 16'h0001);
			if (ms_count == MS_CYCLES[15:0] - 16'h0001)
				ms_count <= 16'h0000;
			else
				ms_count <= ms_count + 16'h0001;
		end
	end

	// Undervoltage warning and torque limit with timed release
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			uv_warning      <= 1'b0;
			releasing       <= 1'b0;
			release_elapsed <= 10'd0;
			release_start   <= `UVTL_NORMAL_LIMIT;
			torque_limit    <= `UVTL_NORMAL_LIMIT;
		end
		else if (clk_en)
		begin
			uv_warning <= uv_now;
			if (mode_active != `UVTL_MODE_INTERNAL)
			begin
				// Host mode leaves limiting to the host controller
				releasing    <= 1'b0;
				torque_limit <= `UVTL_NORMAL_LIMIT;
			end
			else if (uv_now)
			begin
				releasing       <= 1'b0;
				release_elapsed <= 10'd0;
				release_start   <= uv_lim_c;
				torque_limit    <= uv_lim_c;
			end
			else if (uv_warning)
			begin
				// Warning just cleared: start the ramp from the clamp value
				releasing       <= (rel_c != 10'd0);
				release_elapsed <= 10'd0;
				torque_limit    <= (rel_c == 10'd0) ? `UVTL_NORMAL_LIMIT : release_start;
			end
			else if (releasing)
			begin
				torque_limit <= ramp_value;
				if (ms_tick)
				begin
					release_elapsed <= release_elapsed + 10'd1;
					if (release_elapsed + 10'd1 >= rel_c)
						releasing <= 1'b0;
				end
			end
			else
				torque_limit <= `UVTL_NORMAL_LIMIT;
		end
	end

	// Power cut hold timer, servo-on gating and ready
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cut_elapsed    <= 10'd0;
			power_tripped  <= 1'b0;
			servo_ready    <= 1'b0;
			motor_power_en <= 1'b0;
		end
		else if (clk_en)
		begin
			if (main_power_ok)
			begin
				cut_elapsed   <= 10'd0;
				power_tripped <= 1'b0;
			end
			else if (ms_tick && !power_tripped)
			begin
				cut_elapsed <= cut_elapsed + 10'd1;
				if (cut_elapsed + 10'd1 >= hold_c)
					power_tripped <= 1'b1;
			end
			servo_ready    <= ~power_tripped & ~events[`UVTL_INT_POWER_TRIP] &
			                  ~ol_alarm_low & ~ol_alarm_high;
			// Servo-off cuts current at once, the hold timer never delays it
			motor_power_en <= servo_on & ~power_tripped & ~events[`UVTL_INT_POWER_TRIP] &
			                  ~ol_alarm_low & ~ol_alarm_high;
		end
	end

	// Overload accumulation against the derated base current
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ol_accum      <= 24'h00_0000;
			warn_out      <= 1'b0;
			ol_alarm_low  <= 1'b0;
			ol_alarm_high <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ms_tick)
			begin
				if (motor_current > derated_base)
					ol_accum <= (ol_accum + {8'h00, over} < ol_accum) ? 24'hFF_FFFF :
					            ol_accum + {8'h00, over};
				else if (ol_accum != 24'h00_0000)
					ol_accum <= ol_accum - 24'h00_0001; // Slow cool-down
			end
			warn_out <= ol_warn_now;
			if (wr_en && hit_ctrl && pwdata[`UVTL_CTRL_ALM_CLR])
			begin
				ol_alarm_low  <= ol_alarm_now;
				ol_alarm_high <= high_now;
			end
			else
			begin
				ol_alarm_low  <= ol_alarm_low | ol_alarm_now;
				ol_alarm_high <= ol_alarm_high | high_now;
			end
		end
	end

	// Interrupt status and level output
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_status <= {`UVTL_INT_W{1'b0}};
			irq        <= 1'b0;
		end
		else if (clk_en)
		begin
			int_status <= next_int_status;
			irq        <= |(next_int_status & int_mask);
		end
	end

endmodule
`default_nettype wire

// File: tb/uvtl_asserts.sv
// Checker that ties the block's protection outputs to their causes
`timescale 1ns/100ps
`default_nettype none
module uvtl_asserts
#(
	parameter MS_CYCLES = 8
)
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        uv_detect,
	input wire logic        main_power_ok,
	input wire logic        servo_on,
	input wire logic [15:0] motor_current,
	input wire logic [6:0]  torque_limit,
	input wire logic        uv_warning,
	input wire logic        warn_out,
	input wire logic        ol_alarm_low,
	input wire logic        ol_alarm_high,
	input wire logic        servo_ready,
	input wire logic        motor_power_en
);
	logic [15:0] off_cnt;
	// Outage length; saturates so a long cut cannot wrap under the bound
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			off_cnt <= 16'h0000;
		else if (main_power_ok)
			off_cnt <= 16'h0000;
		else if (off_cnt != 16'hFFFF)
			off_cnt <= off_cnt + 16'h0001;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_uv_cause;
		$rose(uv_warning) |-> $past(uv_detect);
	endproperty
	a_uv_cause: assert property (p_uv_cause) else $error("warning without detect");
	property p_uv_hold;
		uv_warning && $past(uv_warning) && torque_limit != 7'h64 |-> $stable(torque_limit);
	endproperty
	a_uv_hold: assert property (p_uv_hold) else $error("clamp moved");
	property p_release;
		$fell(uv_warning) |-> ##[1:1000] torque_limit == 7'h64;
	endproperty
	a_release: assert property (p_release) else $error("release late");
	property p_warn_first;
		$rose(ol_alarm_low) |-> ##[0:2] warn_out;
	endproperty
	a_warn_first: assert property (p_warn_first) else $error("alarm without warning");
	property p_high;
		motor_current >= 16'h0C00 |-> ##[1:2] ol_alarm_high;
	endproperty
	a_high: assert property (p_high) else $error("high alarm missed");
	property p_servo_off;
		!servo_on |=> !motor_power_en;
	endproperty
	a_servo_off: assert property (p_servo_off) else $error("current not cut");
	property p_ride;
		$fell(servo_ready) && !main_power_ok && !ol_alarm_low && !ol_alarm_high
			|-> off_cnt >= 19 * MS_CYCLES;
	endproperty
	a_ride: assert property (p_ride) else $error("trip before hold");
	property p_ramp;
		!uv_warning && !$past(uv_warning) |-> torque_limit >= $past(torque_limit);
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp fell");
endmodule
`default_nettype wire

// File: tb/uvtl_host_model.sv
// Host controller model: answers the warning with its own limit and drives servo-on
`timescale 1ns/100ps
`default_nettype none
module uvtl_host_model
#(
	parameter logic [6:0] HOLD_LIMIT = 7'h28
)
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       host_mode,
	input  wire logic       uv_warning,
	input  wire logic       servo_cmd,
	output var  logic       servo_on,
	output var  logic [6:0] host_limit
);
	// Limit stays until the warning has cleared; never below axis holding torque
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			host_limit <= 7'h64;
			servo_on <= 1'h0;
		end
		else
		begin
			host_limit <= (host_mode && uv_warning) ? HOLD_LIMIT : 7'h64;
			servo_on <= servo_cmd;
		end
	end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the undervoltage torque limit and overload block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int MS = 8;
	logic        pclk = 1'h0;
	logic        presetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        uv_detect = 1'h0;
	logic        main_power_ok = 1'h1;
	logic        servo_cmd = 1'h1;
	logic        clk_en = 1'h1;
	logic        host_mode = 1'h0;
	logic        servo_on;
	logic [15:0] motor_current = 16'h0000;
	logic [6:0]  torque_limit;
	logic [6:0]  host_limit;
	logic        uv_warning, warn_out, ol_alarm_low, ol_alarm_high;
	logic        servo_ready, motor_power_en, irq;
	int          num_errors = 0;
	int          n_compared = 0;

	uvtl_top #(.MS_CYCLES(MS)) uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .uv_detect(uv_detect), .main_power_ok(main_power_ok),
		.servo_on(servo_on), .motor_current(motor_current), .torque_limit(torque_limit),
		.uv_warning(uv_warning), .warn_out(warn_out), .ol_alarm_low(ol_alarm_low),
		.ol_alarm_high(ol_alarm_high), .servo_ready(servo_ready),
		.motor_power_en(motor_power_en), .irq(irq));
	uvtl_host_model u_host (.pclk(pclk), .presetn(presetn), .host_mode(host_mode),
		.uv_warning(uv_warning), .servo_cmd(servo_cmd), .servo_on(servo_on),
		.host_limit(host_limit));

	// Free-running 40 MHz clock
	always #12.5 pclk = ~pclk;

	task chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'h1)
		begin
			num_errors++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One transfer; an idle edge first so psel is never driven twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Only the watchdog bounds this wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'h1);
		chk(pready === 1'h1, "no pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task t_regs;
		apb(1'h0, 8'h04, 32'h0000_0000);
		chk(rd === 32'h0000_0032, "limit reset");
		apb(1'h0, 8'h08, 32'h0000_0000);
		chk(rd === 32'h0000_0064, "release reset");
		apb(1'h0, 8'h10, 32'h0000_0000);
		chk(rd === 32'h0000_0014, "level reset");
		apb(1'h0, 8'h14, 32'h0000_0000);
		chk(rd === 32'h0000_0064, "derating reset");
		apb(1'h0, 8'h28, 32'h0000_0000);
		chk(er === 1'h1 && rd === 32'h0000_0000, "unmapped");
		$display("test regs done");
	endtask
	task t_off;
		uv_detect <= 1'h1;
		cyc(4);
		chk(uv_warning === 1'h0 && torque_limit === 7'h64, "mode off");
		uv_detect <= 1'h0;
		$display("test off done");
	endtask
	task t_internal;
		apb(1'h1, 8'h00, 32'h0000_0102);
		apb(1'h0, 8'h18, 32'h0000_0000);
		chk(rd[24:23] === 2'h2, "mode");
		apb(1'h1, 8'h04, 32'h0000_001E);
		apb(1'h1, 8'h08, 32'h0000_000A);
		apb(1'h1, 8'h20, 32'h0000_0001);
		clk_en <= 1'h0;
		uv_detect <= 1'h1;
		cyc(4);
		chk(uv_warning === 1'h0 && torque_limit === 7'h64 && irq === 1'h0, "frozen");
		clk_en <= 1'h1;
		cyc(4);
		chk(uv_warning === 1'h1 && torque_limit === 7'h1E && irq === 1'h1, "clamp");
		apb(1'h1, 8'h1C, 32'h0000_0001);
		cyc(3);
		chk(irq === 1'h0 && torque_limit === 7'h1E, "held");
		uv_detect <= 1'h0;
		cyc(8 * MS);
		chk(torque_limit > 7'h1E && torque_limit < 7'h64, "ramp");
		cyc(4 * MS);
		chk(torque_limit === 7'h64, "release");
		$display("test internal done");
	endtask
	task t_power;
		main_power_ok <= 1'h0;
		cyc(10 * MS);
		chk(servo_ready === 1'h1 && motor_power_en === 1'h1, "ride");
		main_power_ok <= 1'h1;
		cyc(4);
		main_power_ok <= 1'h0;
		cyc(25 * MS);
		chk(servo_ready === 1'h0 && motor_power_en === 1'h0, "trip");
		main_power_ok <= 1'h1;
		cyc(4);
		chk(servo_ready === 1'h1, "recover");
		servo_cmd <= 1'h0;
		cyc(3);
		chk(motor_power_en === 1'h0, "servo off");
		servo_cmd <= 1'h1;
		cyc(3);
		$display("test power done");
	endtask
	task t_host;
		apb(1'h1, 8'h00, 32'h0000_0101);
		apb(1'h1, 8'h0C, 32'h0000_03E8);
		host_mode <= 1'h1;
		uv_detect <= 1'h1;
		cyc(4);
		chk(uv_warning === 1'h1 && torque_limit === 7'h64 && host_limit === 7'h28, "host");
		chk(irq === 1'h1, "uv irq");
		uv_detect <= 1'h0;
		cyc(4);
		chk(uv_warning === 1'h0 && host_limit === 7'h64, "host clear");
		// Clear every sticky bit so later scenarios start with a quiet irq
		apb(1'h1, 8'h1C, 32'h0000_001F);
		cyc(1);
		chk(irq === 1'h0, "irq cleared");
		$display("test host done");
	endtask
	task t_overload;
		apb(1'h1, 8'h24, 32'h0000_1000);
		apb(1'h1, 8'h10, 32'h0000_0032);
		motor_current <= 16'h0300;
		cyc(10 * MS);
		chk(warn_out === 1'h0, "below base");
		apb(1'h1, 8'h14, 32'h0000_0032);
		apb(1'h1, 8'h00, 32'h0000_0101);
		cyc(11 * MS);
		chk(warn_out === 1'h1 && ol_alarm_low === 1'h0 && irq === 1'h0, "warn");
		cyc(8 * MS);
		chk(ol_alarm_low === 1'h1, "low alarm");
		motor_current <= 16'h0C00;
		cyc(3);
		chk(ol_alarm_high === 1'h1, "high alarm");
		motor_current <= 16'h0000;
		$display("test overload done");
	endtask
	task results;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence; overload last since its alarms drop servo-ready
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_regs;
		t_off;
		t_internal;
		t_power;
		t_host;
		t_overload;
		results;
	end
	// Watchdog well beyond the roughly 730 cycles the tests need
	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		results;
	end
endmodule

bind uvtl_top uvtl_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn),
	.uv_detect(uv_detect), .main_power_ok(main_power_ok), .servo_on(servo_on),
	.motor_current(motor_current), .torque_limit(torque_limit), .uv_warning(uv_warning),
	.warn_out(warn_out), .ol_alarm_low(ol_alarm_low), .ol_alarm_high(ol_alarm_high),
	.servo_ready(servo_ready), .motor_power_en(motor_power_en));
`default_nettype wire
